// [verification/ddr_ctrl_model.sv]
module ddr_ctrl_model
	import ddr_port_pkg::*;
#(
	parameter int W = WORD_W_DEFAULT
) (
	// link clock and device enables
	input  wire logic         k_clk,
	input  wire logic         oe_r,
	input  wire logic         oe_f,
	// controller write word
	input  wire logic         drv_en,
	input  wire logic [W-1:0] drv_word,
	// pin level seen by the device
	output logic      [W-1:0] dq_in
);
	timeunit 1ns;
	timeprecision 100ps;
	initial dq_in = '0;
	// released pins flip every half cycle so a stale word never looks valid
	always @(k_clk or drv_en or drv_word) begin
		if (drv_en && !oe_r && !oe_f) dq_in = drv_word;
		else if (!drv_en) dq_in = ~dq_in;
	end
endmodule

// [verification/ddr_port_properties.sv]
module ddr_port_properties
	import ddr_port_pkg::*;
(
	// link clocks and reset
	input wire logic K_CLK,
	input wire logic K_CLK_N,
	input wire logic RST,
	// command
	input wire logic LOAD_N,
	input wire logic READ_NOT_WRITE,
	input wire logic LATENCY_MODE_SELECT,
	// device lanes
	input wire logic DQ_OE_RISE,
	input wire logic DQ_OE_FALL,
	input wire logic READ_VALID_FLAG_RISE,
	input wire logic READ_VALID_FLAG_FALL,
	input wire logic ECHO_CLOCK_OUT_RISE,
	input wire logic ECHO_CLOCK_OUT_FALL
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------------------------------
	// slot tracking
	// ----------------------------------------------------------------
	logic [1:0] kr;
	logic       ph;
	logic       slot_cmd;
	always_ff @(posedge K_CLK or posedge RST) begin
		if (RST) begin
			kr <= 2'h0;
			ph <= 1'b0;
		end else begin
			ph <= ~ph;
			if (kr != 2'h3) kr <= kr + 2'h1;
		end
	end
	// link logic leaves reset after two edges; its first slot samples on the fourth
	assign slot_cmd = (kr >= 2'h2) && ph && (LOAD_N == CMD_LOAD_ACTIVE);

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	a_read_long_lat: assert property (@(posedge K_CLK) disable iff (RST)
		slot_cmd && READ_NOT_WRITE && LATENCY_MODE_SELECT |-> ##2 !DQ_OE_RISE ##1 DQ_OE_RISE)
		else $error("long read launched at wrong edge");
	a_read_short_lat: assert property (@(posedge K_CLK) disable iff (RST)
		slot_cmd && READ_NOT_WRITE && !LATENCY_MODE_SELECT |-> ##1 !DQ_OE_RISE ##1 DQ_OE_RISE)
		else $error("short read launched at wrong edge");
	a_write_no_drive: assert property (@(posedge K_CLK) disable iff (RST)
		slot_cmd && !READ_NOT_WRITE |-> ##2 !DQ_OE_RISE [*2])
		else $error("pins driven after write");
	a_rise_one_half: assert property (@(posedge K_CLK) disable iff (RST)
		DQ_OE_RISE |=> !DQ_OE_RISE)
		else $error("true lane driven too long");
	a_fall_follows: assert property (@(posedge K_CLK_N) disable iff (RST)
		DQ_OE_FALL == $past(DQ_OE_RISE))
		else $error("second word not on complementary edge");
	a_valid_rise_oe: assert property (@(posedge K_CLK) disable iff (RST)
		READ_VALID_FLAG_RISE == DQ_OE_RISE)
		else $error("valid flag differs from true lane");
	a_valid_fall_oe: assert property (@(posedge K_CLK_N) disable iff (RST)
		READ_VALID_FLAG_FALL == DQ_OE_FALL)
		else $error("valid flag differs from complementary lane");
	a_echo_rise_tgl: assert property (@(posedge K_CLK) disable iff (RST)
		kr == 2'h3 |-> ECHO_CLOCK_OUT_RISE != $past(ECHO_CLOCK_OUT_RISE))
		else $error("echo toggle missed on true edge");
	a_echo_fall_tgl: assert property (@(posedge K_CLK_N) disable iff (RST)
		kr == 2'h3 |-> ECHO_CLOCK_OUT_FALL != $past(ECHO_CLOCK_OUT_FALL))
		else $error("echo toggle missed on complementary edge");
	c_long: cover property (@(posedge K_CLK) slot_cmd && READ_NOT_WRITE && LATENCY_MODE_SELECT);
	c_short: cover property (@(posedge K_CLK) slot_cmd && READ_NOT_WRITE && !LATENCY_MODE_SELECT);
	c_write: cover property (@(posedge K_CLK) slot_cmd && !READ_NOT_WRITE);
endmodule

// [verification/testbench.sv]
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
	$display("unexpected %s: expected %0h, seen %0h", n, e, g); end end
module testbench
	import ddr_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clock, rst, k_clk, k_clk_n, load_n, rnw, lat, drv_en;
	logic [5:0]  addr;
	logic [17:0] drv_word, dq_in, out_r, out_f;
	logic        oe_r, oe_f, vr, vf, er, ef;
	logic [15:0] rc, wc;
	int          failures, n_tests, kcnt;
	assign k_clk_n = ~k_clk;
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	initial begin
		k_clk = 1'b0;
		#2 k_clk = 1'b1;
		forever #7.5 k_clk = ~k_clk;
	end
	always @(posedge k_clk or posedge rst) kcnt <= rst ? 0 : kcnt + 1;
	ddr_burst2_sram_port #(.ADDR_W(6)) ddr_burst2_sram_port_inst (.CLOCK(clock), .RST(rst),
		.K_CLK(k_clk), .K_CLK_N(k_clk_n), .LOAD_N(load_n), .READ_NOT_WRITE(rnw), .ADDR(addr),
		.LATENCY_MODE_SELECT(lat), .DQ_IN(dq_in), .DQ_OUT_RISE(out_r), .DQ_OE_RISE(oe_r),
		.DQ_OUT_FALL(out_f), .DQ_OE_FALL(oe_f), .READ_VALID_FLAG_RISE(vr),
		.READ_VALID_FLAG_FALL(vf), .ECHO_CLOCK_OUT_RISE(er), .ECHO_CLOCK_OUT_FALL(ef),
		.READ_COUNT(rc), .WRITE_COUNT(wc));
	ddr_ctrl_model #(.W(18)) ddr_ctrl_model_inst (.k_clk(k_clk), .oe_r(oe_r), .oe_f(oe_f),
		.drv_en(drv_en), .drv_word(drv_word), .dq_in(dq_in));
	// ----------------------------------------------------------------
	// link tasks
	// ----------------------------------------------------------------
	task automatic kstep(int n);
		repeat (n) @(posedge k_clk);
		#1;
	endtask
	task automatic cmd(logic r, logic [5:0] a, logic skip);
		kstep(1);
		if (kcnt[0] == skip) kstep(1);
		load_n = 1'b0;
		rnw = r;
		addr = a;
		kstep(1);
		load_n = 1'b1;
	endtask
	task automatic wr(logic [5:0] a, logic [17:0] w0, logic [17:0] w1);
		cmd(1'b0, a, 1'b0);
		drv_word = w0;
		drv_en = 1'b1;
		kstep(1);
		drv_word = w1;
		@(posedge k_clk_n) #1;
		drv_en = 1'b0;
	endtask
	task automatic rd(logic [5:0] a, logic [17:0] w0, logic [17:0] w1, int lt);
		cmd(1'b1, a, 1'b0);
		kstep(lt);
		`CHK("word0", w0, out_r)
		`CHK("oe0", 1'b1, oe_r)
		`CHK("valid0", 1'b1, vr)
		@(posedge k_clk_n) #1;
		`CHK("word1", w1, out_f)
		`CHK("oe1", 1'b1, oe_f)
		`CHK("valid1", 1'b1, vf)
		kstep(1);
		`CHK("oe_end", 1'b0, oe_r)
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_pairs();
		wr(6'h05, 18'h2A5A5, 18'h15A5A);
		wr(6'h09, 18'h3FFFF, 18'h00001);
		rd(6'h09, 18'h3FFFF, 18'h00001, READ_LAT_LONG);
		rd(6'h05, 18'h2A5A5, 18'h15A5A, READ_LAT_LONG);
	endtask
	task automatic t_skip();
		logic e0;
		cmd(1'b1, 6'h05, 1'b1);
		e0 = er;
		repeat (4) begin
			kstep(1);
			`CHK("skip_oe", 1'b0, oe_r)
			`CHK("echo_rise", ~e0, er)
			e0 = er;
		end
	endtask
	task automatic t_short();
		lat = ~LAT_SEL_LONG;
		kstep(6);
		rd(6'h05, 18'h2A5A5, 18'h15A5A, READ_LAT_SHORT);
	endtask
	task automatic t_counts();
		kstep(3);
		`CHK("reads", 16'h0003, rc)
		`CHK("writes", 16'h0002, wc)
	endtask
	task automatic tally_and_finish();
		if (failures == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#60000;
		failures++;
		tally_and_finish();
	end
	initial begin
		rst = 1'b1;
		load_n = 1'b1;
		rnw = 1'b0;
		addr = 6'h00;
		lat = LAT_SEL_LONG;
		drv_en = 1'b0;
		drv_word = 18'h00000;
		failures = 0;
		n_tests = 0;
		repeat (5) @(posedge clock);
		#1 rst = 1'b0;
		kstep(3);
		t_pairs();
		t_skip();
		t_short();
		t_counts();
		tally_and_finish();
	end
endmodule
bind ddr_burst2_sram_port ddr_port_properties props_inst (.K_CLK(K_CLK), .K_CLK_N(K_CLK_N),
	.RST(RST), .LOAD_N(LOAD_N), .READ_NOT_WRITE(READ_NOT_WRITE),
	.LATENCY_MODE_SELECT(LATENCY_MODE_SELECT), .DQ_OE_RISE(DQ_OE_RISE),
	.DQ_OE_FALL(DQ_OE_FALL), .READ_VALID_FLAG_RISE(READ_VALID_FLAG_RISE),
	.READ_VALID_FLAG_FALL(READ_VALID_FLAG_FALL), .ECHO_CLOCK_OUT_RISE(ECHO_CLOCK_OUT_RISE),
	.ECHO_CLOCK_OUT_FALL(ECHO_CLOCK_OUT_FALL));

// [verilog/burst_pair_mem.sv]
// ----------------------------------------------------------------
// two-word pair array: one write port, one registered read port
// ----------------------------------------------------------------
module burst_pair_mem
	import ddr_port_pkg::*;
#(
	parameter int WORD_W = WORD_W_DEFAULT,
	parameter int ADDR_W = ADDR_W_DEFAULT
) (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst,
	// write port
	input  wire logic                wr_en,
	input  wire logic [ADDR_W-1:0]   wr_addr,
	input  wire logic [2*WORD_W-1:0] wr_data,
	// read port
	input  wire logic                rd_en,
	input  wire logic [ADDR_W-1:0]   rd_addr,
	output logic      [2*WORD_W-1:0] rd_data
);

	logic [2*WORD_W-1:0] array_reg [0:(1<<ADDR_W)-1];

	// array carries no reset: contents are undefined after power-up
	always_ff @(posedge clk) begin
		if (wr_en) begin
			array_reg[wr_addr] <= wr_data;
		end
	end

	// read register doubles as the rising-edge output register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data <= '0;
		end else if (rd_en) begin
			rd_data <= array_reg[rd_addr];
		end
	end

endmodule

// [verilog/ddr_burst2_sram_port.sv]
// Operation
// R01: address sampled on alternate true-clock edges
// R02: write words on true, then complementary edge
// R03: read words launched on both clock edges
// R04: each address holds an ordered word pair
// R05: select high gives two-cycle read latency
// R06: select low gives one-cycle read latency
// R07: valid flag marks read data on pins
// R08: shared data pins, device drives only reads
// R09: complementary echo clocks track read data
// R10: inputs and outputs pass clock-edge registers
// R11: write completes self-timed, no extra strobes
// R12: only rising edges of either clock act
// R13: controller releases pins around read bursts
module ddr_burst2_sram_port
	import ddr_port_pkg::*;
#(
	parameter int WORD_W  = WORD_W_DEFAULT,
	parameter int ADDR_W  = ADDR_W_DEFAULT,
	parameter int COUNT_W = COUNT_W_DEFAULT
) (
	// system clock and reset
	input  wire logic               CLOCK,
	input  wire logic               RST,
	// link input clocks
	input  wire logic               K_CLK,
	input  wire logic               K_CLK_N,
	// command and address
	input  wire logic               LOAD_N,
	input  wire logic               READ_NOT_WRITE,
	input  wire logic [ADDR_W-1:0]  ADDR,
	input  wire logic               LATENCY_MODE_SELECT,
	// shared data pins, true-edge lane and complementary-edge lane
	input  wire logic [WORD_W-1:0]  DQ_IN,
	output logic      [WORD_W-1:0]  DQ_OUT_RISE,
	output logic                    DQ_OE_RISE,
	output logic      [WORD_W-1:0]  DQ_OUT_FALL,
	output logic                    DQ_OE_FALL,
	// read valid flag lanes
	output logic                    READ_VALID_FLAG_RISE,
	output logic                    READ_VALID_FLAG_FALL,
	// echo clock toggles
	output logic                    ECHO_CLOCK_OUT_RISE,
	output logic                    ECHO_CLOCK_OUT_FALL,
	// activity counters on the system clock
	output logic      [COUNT_W-1:0] READ_COUNT,
	output logic      [COUNT_W-1:0] WRITE_COUNT
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (!(WORD_W == 8 || WORD_W == 9 || WORD_W == 18 || WORD_W == 36)) begin : g_bad_width
		$error("WORD_W must be 8, 9, 18 or 36");
	end
	if (ADDR_W < 1 || ADDR_W > 24) begin : g_bad_addr
		$error("ADDR_W must lie in 1..24");
	end
	if (COUNT_W < 1) begin : g_bad_count
		$error("COUNT_W must be at least 1");
	end
	if (BURST_WORDS != 2) begin : g_bad_burst
		$error("the pair array serves two-word bursts only");
	end

	function automatic logic [COUNT_W-1:0] count_up(input logic [COUNT_W-1:0] v,
			input logic hit);
		count_up = hit ? v + COUNT_W'(1) : v;
	endfunction

	function automatic slot_e next_slot(input slot_e s);
		next_slot = (s == SLOT_CMD) ? SLOT_SKIP : SLOT_CMD;
	endfunction

	// ----------------------------------------------------------------
	// reset release per link domain
	// ----------------------------------------------------------------
	// assert at once with RST, release two edges later on each clock
	// each domain releases on its own edges, so no flop leaves reset mid-setup
	logic [1:0] k_rst_pipe_reg;
	logic [1:0] kn_rst_pipe_reg;
	logic       k_rst;
	logic       kn_rst;

	always_ff @(posedge K_CLK or posedge RST) begin
		if (RST) begin
			k_rst_pipe_reg <= 2'h3;
		end else begin
			k_rst_pipe_reg <= {k_rst_pipe_reg[0], 1'b0};
		end
	end

	always_ff @(posedge K_CLK_N or posedge RST) begin
		if (RST) begin
			kn_rst_pipe_reg <= 2'h3;
		end else begin
			kn_rst_pipe_reg <= {kn_rst_pipe_reg[0], 1'b0};
		end
	end

	assign k_rst = k_rst_pipe_reg[1];
	assign kn_rst = kn_rst_pipe_reg[1];

	// ----------------------------------------------------------------
	// true-clock domain
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              load_n_in;
		logic              rnw_in;
		logic [ADDR_W-1:0] addr_in;
		logic [WORD_W-1:0] din_in;
		logic              lat_meta;
		logic              lat_sync;
		slot_e             slot;
		logic              rd_dly;
		logic [ADDR_W-1:0] rd_dly_addr;
		logic              wr_data_cyc;
		logic [ADDR_W-1:0] wr_addr;
		logic              launch;
		logic              echo;
		logic              rd_tgl;
		logic              wr_tgl;
	} kdom_s;

	kdom_s k_reg;
	kdom_s k_next;

	logic                cmd_take;
	logic                rd_take;
	logic                wr_take;
	logic                lat_long;
	logic                mem_rd_en;
	logic [ADDR_W-1:0]   mem_rd_addr;
	logic [2*WORD_W-1:0] mem_rd_data;
	logic [WORD_W-1:0]   din_fall_word;

	always_comb begin
		// a command in the input register is taken only in a command slot
		cmd_take = (k_reg.load_n_in == CMD_LOAD_ACTIVE) && (k_reg.slot == SLOT_CMD); // R01
		rd_take = cmd_take && (k_reg.rnw_in == CMD_RW_READ);
		wr_take = cmd_take && (k_reg.rnw_in != CMD_RW_READ);
		lat_long = (k_reg.lat_sync == LAT_SEL_LONG);

		// short latency reads the array at once, long waits one cycle
		if (lat_long) begin
			mem_rd_en = k_reg.rd_dly; // R05
			mem_rd_addr = k_reg.rd_dly_addr;
		end else begin
			mem_rd_en = rd_take; // R06
			mem_rd_addr = k_reg.addr_in;
		end

		k_next = k_reg;
		// every synchronous pin is sampled on each true-clock edge
		k_next.load_n_in = LOAD_N; // R10
		k_next.rnw_in = READ_NOT_WRITE;
		k_next.addr_in = ADDR;
		k_next.din_in = DQ_IN; // R02
		// the mode pin is static but asynchronous to the link clock
		k_next.lat_meta = LATENCY_MODE_SELECT;
		k_next.lat_sync = k_reg.lat_meta;

		// slots alternate freely from reset, commands or not
		k_next.slot = next_slot(k_reg.slot); // R01

		k_next.rd_dly = rd_take && lat_long;
		k_next.rd_dly_addr = k_reg.addr_in;

		// write: first word arrives with the next true edge
		k_next.wr_data_cyc = wr_take; // R02
		if (wr_take) begin
			k_next.wr_addr = k_reg.addr_in;
		end

		// the pair leaves the read register on the edge after the read
		k_next.launch = mem_rd_en; // R03
		// echo runs free so the controller's capture clock never stops
		k_next.echo = ~k_reg.echo; // R09

		if (rd_take) begin
			k_next.rd_tgl = ~k_reg.rd_tgl;
		end
		if (wr_take) begin
			k_next.wr_tgl = ~k_reg.wr_tgl;
		end
	end

	always_ff @(posedge K_CLK or posedge k_rst) begin
		if (k_rst) begin
			k_reg <= '{
				load_n_in:   1'b1,
				rnw_in:      1'b1,
				addr_in:     '0,
				din_in:      '0,
				lat_meta:    LAT_SEL_LONG,
				lat_sync:    LAT_SEL_LONG,
				slot:        SLOT_CMD,
				rd_dly:      1'b0,
				rd_dly_addr: '0,
				wr_data_cyc: 1'b0,
				wr_addr:     '0,
				launch:      1'b0,
				echo:        1'b0,
				rd_tgl:      1'b0,
				wr_tgl:      1'b0
			};
		end else begin
			k_reg <= k_next; // R12
		end
	end

	// ----------------------------------------------------------------
	// pair array
	// ----------------------------------------------------------------
	// the write lands on the true edge that ends the data cycle, using
	// the true-edge word and the complementary-edge word of that cycle
	burst_pair_mem #(
		.WORD_W (WORD_W),
		.ADDR_W (ADDR_W)
	) u_array (
		.clk     (K_CLK),
		.rst     (k_rst),
		.wr_en   (k_reg.wr_data_cyc), // R11
		.wr_addr (k_reg.wr_addr),
		.wr_data ({din_fall_word, k_reg.din_in}), // R04
		.rd_en   (mem_rd_en),
		.rd_addr (mem_rd_addr),
		.rd_data (mem_rd_data)
	);

	// ----------------------------------------------------------------
	// true-edge output lane
	// ----------------------------------------------------------------
	// first word of the pair goes out on the true edge
	assign DQ_OUT_RISE = mem_rd_data[WORD_W-1:0]; // R04
	assign DQ_OE_RISE = k_reg.launch; // R08
	assign READ_VALID_FLAG_RISE = k_reg.launch; // R07
	assign ECHO_CLOCK_OUT_RISE = k_reg.echo; // R09

	// ----------------------------------------------------------------
	// complementary-clock domain
	// ----------------------------------------------------------------
	// both link clocks come from one source in fixed antiphase, so a
	// half-cycle path between them is timed, not resynchronised
	typedef struct packed {
		logic [WORD_W-1:0] din;
		logic [WORD_W-1:0] dout;
		logic              oe;
		logic              valid;
		logic              echo;
	} kndom_s;

	kndom_s kn_reg;
	kndom_s kn_next;

	always_comb begin
		kn_next = kn_reg;
		kn_next.din = DQ_IN; // R02
		kn_next.oe = k_reg.launch; // R08
		kn_next.valid = k_reg.launch; // R07
		if (k_reg.launch) begin
			kn_next.dout = mem_rd_data[2*WORD_W-1:WORD_W]; // R03
		end
		kn_next.echo = ~kn_reg.echo; // R09
	end

	always_ff @(posedge K_CLK_N or posedge kn_rst) begin
		if (kn_rst) begin
			kn_reg <= '{
				din:   '0,
				dout:  '0,
				oe:    1'b0,
				valid: 1'b0,
				echo:  1'b0
			};
		end else begin
			kn_reg <= kn_next; // R12
		end
	end

	// ----------------------------------------------------------------
	// complementary-edge output lane
	// ----------------------------------------------------------------
	assign din_fall_word = kn_reg.din;
	assign DQ_OUT_FALL = kn_reg.dout; // R10
	assign DQ_OE_FALL = kn_reg.oe;
	assign READ_VALID_FLAG_FALL = kn_reg.valid;
	assign ECHO_CLOCK_OUT_FALL = kn_reg.echo;

	// ----------------------------------------------------------------
	// system-clock activity counters
	// ----------------------------------------------------------------
	// toggles cross by two flops; a third flop gives the edge. accepted
	// commands are at least two link cycles apart, slower than the
	// crossing, so no toggle is missed at these clock rates
	typedef struct packed {
		logic               rd_meta;
		logic               rd_sync;
		logic               rd_seen;
		logic               wr_meta;
		logic               wr_sync;
		logic               wr_seen;
		logic [COUNT_W-1:0] rd_count;
		logic [COUNT_W-1:0] wr_count;
	} sdom_s;

	sdom_s s_reg;
	sdom_s s_next;

	always_comb begin
		s_next = s_reg;
		s_next.rd_meta = k_reg.rd_tgl;
		s_next.rd_sync = s_reg.rd_meta;
		s_next.rd_seen = s_reg.rd_sync;
		s_next.wr_meta = k_reg.wr_tgl;
		s_next.wr_sync = s_reg.wr_meta;
		s_next.wr_seen = s_reg.wr_sync;
		s_next.rd_count = count_up(s_reg.rd_count, s_reg.rd_sync ^ s_reg.rd_seen);
		s_next.wr_count = count_up(s_reg.wr_count, s_reg.wr_sync ^ s_reg.wr_seen);
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			s_reg <= '{
				rd_meta:  1'b0,
				rd_sync:  1'b0,
				rd_seen:  1'b0,
				wr_meta:  1'b0,
				wr_sync:  1'b0,
				wr_seen:  1'b0,
				rd_count: '0,
				wr_count: '0
			};
		end else begin
			s_reg <= s_next;
		end
	end

	assign READ_COUNT = s_reg.rd_count;
	assign WRITE_COUNT = s_reg.wr_count;

endmodule

// [verilog/ddr_port_pkg.sv]
package ddr_port_pkg;

	// ----------------------------------------------------------------
	// geometry defaults
	// ----------------------------------------------------------------
	localparam int WORD_W_DEFAULT = 18;
	localparam int ADDR_W_DEFAULT = 20;
	localparam int COUNT_W_DEFAULT = 16;
	localparam int BURST_WORDS = 2;

	// ----------------------------------------------------------------
	// read latency, in input-clock cycles
	// ----------------------------------------------------------------
	localparam int READ_LAT_LONG = 2;
	localparam int READ_LAT_SHORT = 1;

	// latency_mode_select pin level that picks the long latency
	localparam logic LAT_SEL_LONG = 1'b1;

	// command pins: load strobe is active low, rw high means read
	localparam logic CMD_LOAD_ACTIVE = 1'b0;
	localparam logic CMD_RW_READ = 1'b1;

	// ----------------------------------------------------------------
	// address slot on the true input clock
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		SLOT_CMD  = 1'b0,
		SLOT_SKIP = 1'b1
	} slot_e;

endpackage
